// *** hdl/safr_flags.sv ***
// Status flags, limit flags and the tagged result queue, read by command byte.
// Assumes commands arrive as one-cycle strobes from an already decoded serial port.
`timescale 1ns/1ps
`default_nettype none
module safr_flags
	import safr_pkg::*;
#(
	parameter int CONV_CAP  = CONV_DEPTH,
	parameter int TABLE_CAP = TABLE_DEPTH
) (
	// Clock, reset, enable
	input  wire logic                 ref_clk,
	input  wire logic                 rst,
	input  wire logic                 clk_en,
	// Command port
	input  wire logic                 cmd_valid,
	input  wire logic [7:0]           cmd_byte,
	output logic                      rd_valid,
	output logic      [WORD_BITS-1:0] rd_data,
	// Software clear and restart causes
	input  wire logic                 watchdog_reset,
	input  wire logic                 full_reset_cmd,
	input  wire logic                 limit_clear_cmd,
	input  wire logic                 queue_clear_bit,
	// Busy sources
	input  wire logic                 arith_unit_active,
	input  wire logic                 gain_cal_active,
	input  wire logic                 conversion_active,
	input  wire logic                 gate_calc_active,
	// Limit violation events
	input  wire logic                 ch2_gate_over_limit,
	input  wire logic                 ch2_gate_under_limit,
	input  wire logic                 ch2_sense_over_limit,
	input  wire logic                 ch2_sense_under_limit,
	input  wire logic                 ch2_temp_over_limit,
	input  wire logic                 ch2_temp_under_limit,
	input  wire logic                 ch1_gate_over_limit,
	input  wire logic                 ch1_gate_under_limit,
	input  wire logic                 ch1_sense_over_limit,
	input  wire logic                 ch1_sense_under_limit,
	input  wire logic                 ch1_temp_over_limit,
	input  wire logic                 ch1_temp_under_limit,
	// Sample source
	input  wire logic                 sample_valid,
	input  wire logic [3:0]           sample_tag,
	input  wire logic [11:0]          sample_result,
	// Table word source
	input  wire logic                 table_mode,
	input  wire logic                 table_valid,
	input  wire logic                 table_config,
	input  wire logic [12:0]          table_data,
	input  wire logic [3:0]           table_tag,
	output logic                      table_ready,
	// Flag words
	output logic      [WORD_BITS-1:0] busy_status_flags,
	output logic      [WORD_BITS-1:0] limit_violation_flags
);
	initial begin
		if (CONV_CAP < 2 || CONV_CAP > 16 || TABLE_CAP < CONV_CAP || TABLE_CAP > 16)
			$error("safr_flags queue capacity out of range");
	end

	safr_mode_e       mode;
	logic             restart;
	logic             overrun;
	logic [3:0]       busy;
	logic [11:0]      limits;
	logic [11:0]      limit_events;
	logic             rd_status;
	logic             rd_limit;
	logic             rd_queue;
	logic [4:0]       count;
	logic [4:0]       cap;
	logic             q_full;
	logic             q_empty;
	logic             q_push;
	logic [15:0]      q_push_data;
	logic [15:0]      head_data;
	logic             collide;
	logic [6:0]       status_now;

	assign rd_status = cmd_valid && cmd_byte == CMD_READ_STATUS;
	assign rd_limit  = cmd_valid && cmd_byte == CMD_READ_LIMIT;
	assign rd_queue  = cmd_valid && cmd_byte == CMD_READ_QUEUE;
	assign cap       = (mode == SAFR_MODE_TABLE) ? 5'(TABLE_CAP) : 5'(CONV_CAP);
	assign q_full    = count >= cap;
	assign q_empty   = count == 5'h00;
	assign collide   = q_full && rd_queue && sample_valid && mode == SAFR_MODE_CONV;

	// Mode follows the table engine; host keeps the two kinds apart
	always_ff @(posedge ref_clk) begin
		if (rst)
			mode <= SAFR_MODE_CONV;
		else if (clk_en)
			mode <= table_mode ? SAFR_MODE_TABLE : SAFR_MODE_CONV;
	end

	// Queue entry formatting and push
	always_comb begin
		q_push      = 1'b0;
		q_push_data = 16'h0000;
		if (mode == SAFR_MODE_TABLE) begin
			q_push = table_valid && (!q_full || rd_queue);
			if (table_config)
				q_push_data = {table_tag[3:1], table_data};
			else
				q_push_data = {table_tag, table_data[11:0]};
		end else begin
			q_push      = sample_valid;
			q_push_data = {collide ? TAG_CORRUPT : sample_tag, sample_result};
		end
	end

	// Copying stalls once the queue is one word short of full
	always_ff @(posedge ref_clk) begin
		if (rst)
			table_ready <= 1'b0;
		else if (clk_en)
			table_ready <= mode == SAFR_MODE_TABLE && count < cap - 5'h01;
	end

	safr_queue #(
		.WIDTH (WORD_BITS),
		.DEPTH (TABLE_CAP)
	) u_queue (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.clk_en    (clk_en),
		.flush     (queue_clear_bit),
		.push      (q_push),
		.drop      (mode == SAFR_MODE_CONV),
		.push_data (q_push_data),
		.pop       (rd_queue),
		.limit     (cap),
		.head_data (head_data),
		.count     (count)
	);

	// Restart history; event beats the read clear
	always_ff @(posedge ref_clk) begin
		if (rst)
			restart <= STAT_RESET[STAT_RESTART];
		else if (clk_en) begin
			if (watchdog_reset || full_reset_cmd)
				restart <= 1'b1;
			else if (rd_status)
				restart <= 1'b0;
		end
	end

	// Overrun, sticky for samples, live fullness for table words
	always_ff @(posedge ref_clk) begin
		if (rst)
			overrun <= STAT_RESET[STAT_OVERRUN];
		else if (clk_en) begin
			if (mode == SAFR_MODE_TABLE)
				overrun <= q_full;
			else if (sample_valid && q_full && !rd_queue)
				overrun <= 1'b1;
			else if (rd_status || queue_clear_bit)
				overrun <= 1'b0;
		end
	end

	// Busy sources registered once
	always_ff @(posedge ref_clk) begin
		if (rst)
			busy <= STAT_RESET[5:2];
		else if (clk_en)
			busy <= {arith_unit_active, gain_cal_active, conversion_active,
				gate_calc_active};
	end

	assign status_now = {restart, busy, q_empty, overrun};

	assign limit_events = {ch2_gate_over_limit, ch2_gate_under_limit,
		ch2_sense_over_limit, ch2_sense_under_limit,
		ch2_temp_over_limit, ch2_temp_under_limit,
		ch1_gate_over_limit, ch1_gate_under_limit,
		ch1_sense_over_limit, ch1_sense_under_limit,
		ch1_temp_over_limit, ch1_temp_under_limit};

	// New events win over the clear so none is lost
	always_ff @(posedge ref_clk) begin
		if (rst)
			limits <= LIMIT_RESET;
		else if (clk_en) begin
			if (rd_limit || limit_clear_cmd)
				limits <= limit_events;
			else
				limits <= limits | limit_events;
		end
	end

	// Flag word outputs
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			busy_status_flags     <= {9'h000, STAT_RESET};
			limit_violation_flags <= {4'h0, LIMIT_RESET};
		end else if (clk_en) begin
			busy_status_flags     <= {9'h000, status_now};
			limit_violation_flags <= {4'h0, limits};
		end
	end

	// Read answers one cycle after the command
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rd_valid <= 1'b0;
			rd_data  <= 16'h0000;
		end else if (clk_en) begin
			rd_valid <= rd_status || rd_limit || rd_queue;
			if (rd_status)
				rd_data <= {9'h000, status_now};
			else if (rd_limit)
				rd_data <= {4'h0, limits};
			else if (rd_queue && q_empty)
				rd_data <= {TAG_EMPTY, 5'h00, status_now};
			else if (rd_queue)
				rd_data <= head_data;
		end
	end

	a_restart_clear: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && rd_status && !watchdog_reset && !full_reset_cmd |=> !restart)
		else $error("restart not cleared by status read");
	a_restart_set: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && watchdog_reset |=> restart)
		else $error("restart not set");
	a_overrun_stick: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && mode == SAFR_MODE_CONV && overrun && !rd_status && !queue_clear_bit
		&& !table_mode |=> overrun)
		else $error("overrun dropped without clear");
	a_limit_clear: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && rd_limit && limit_events == 12'h000 |=> limits == 12'h000)
		else $error("limits not cleared on read");
	a_limit_latch: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && ch2_gate_over_limit |=> limits[11])
		else $error("channel two gate over limit not latched");
	a_empty_tag: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && rd_queue && q_empty |=> rd_valid && rd_data[15:12] == TAG_EMPTY)
		else $error("empty read tag wrong");
	a_conv_cap: assert property (@(posedge ref_clk) disable iff (rst)
		mode == SAFR_MODE_CONV |-> count <= 5'(CONV_CAP) || $past(table_mode))
		else $error("sample queue above capacity");
	a_table_no_over: assert property (@(posedge ref_clk) disable iff (rst)
		count <= 5'(TABLE_CAP))
		else $error("table queue overflowed");
	a_upper_zero: assert property (@(posedge ref_clk) disable iff (rst)
		busy_status_flags[15:7] == 9'h000 && limit_violation_flags[15:12] == 4'h0)
		else $error("undefined bits not zero");
	a_clear_empty: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && queue_clear_bit ##1 clk_en |=> busy_status_flags[STAT_EMPTY])
		else $error("queue clear did not show empty");
	a_overrun_set: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && mode == SAFR_MODE_CONV && sample_valid && q_full && !rd_queue |=> overrun)
		else $error("sample overflow did not flag overrun");
	a_table_live: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && mode == SAFR_MODE_TABLE |=> overrun == $past(q_full))
		else $error("table overrun not live fullness");
	// A dropped table word would shift every later word the host counts
	a_table_hold: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && mode == SAFR_MODE_TABLE && q_full && !rd_queue && !queue_clear_bit
		|=> count == $past(count))
		else $error("table copy did not pause on full queue");
	a_queue_answer: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && rd_queue && !q_empty |=> rd_valid && rd_data == $past(head_data))
		else $error("queue read answer wrong");
	a_status_answer: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && rd_status |=> rd_valid && rd_data == {9'h000, $past(status_now)})
		else $error("status read answer wrong");
	a_limit_answer: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && rd_limit |=> rd_valid && rd_data == {4'h0, $past(limits)})
		else $error("limit read answer wrong");
	a_limit_keep: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && limits[0] && !rd_limit && !limit_clear_cmd |=> limits[0])
		else $error("latched limit flag lost");
	a_busy_copy: assert property (@(posedge ref_clk) disable iff (rst)
		clk_en && conversion_active |=> busy[1])
		else $error("conversion busy not reported");

	c_overflow: cover property (@(posedge ref_clk) disable iff (rst)
		mode == SAFR_MODE_CONV && q_full && sample_valid);
	c_collide: cover property (@(posedge ref_clk) disable iff (rst) collide);
	c_table_stall: cover property (@(posedge ref_clk) disable iff (rst)
		mode == SAFR_MODE_TABLE && q_full && table_valid);
	c_empty_read: cover property (@(posedge ref_clk) disable iff (rst) rd_queue && q_empty);
	c_restart_read: cover property (@(posedge ref_clk) disable iff (rst) restart && rd_status);
endmodule
`default_nettype wire

// *** common/safr_pkg.sv ***
// Constants for the status, limit flag and result queue block.
// Assumes a single clock domain; command bytes arrive already decoded.
package safr_pkg;
	localparam logic [7:0]  CMD_READ_STATUS = 8'hf6;
	localparam logic [7:0]  CMD_READ_LIMIT  = 8'hf8;
	localparam logic [7:0]  CMD_READ_QUEUE  = 8'h80;
	localparam int          STAT_RESTART    = 6;
	localparam int          STAT_ARITH      = 5;
	localparam int          STAT_GAIN       = 4;
	localparam int          STAT_CONV       = 3;
	localparam int          STAT_GATE       = 2;
	localparam int          STAT_EMPTY      = 1;
	localparam int          STAT_OVERRUN    = 0;
	localparam int          STAT_BITS       = 7;
	localparam int          LIMIT_BITS      = 12;
	localparam int          WORD_BITS       = 16;
	localparam int          TAG_BITS        = 4;
	localparam int          CONV_DEPTH      = 15;
	localparam int          TABLE_DEPTH     = 16;
	localparam logic [3:0]  TAG_EMPTY       = 4'hf;
	localparam logic [3:0]  TAG_CORRUPT     = 4'he;
	localparam logic [6:0]  STAT_RESET      = 7'h06;
	localparam logic [11:0] LIMIT_RESET     = 12'h000;
	typedef enum logic [1:0] {
		SAFR_MODE_CONV  = 2'b01,
		SAFR_MODE_TABLE = 2'b10
	} safr_mode_e;
endpackage

// *** hdl/safr_queue.sv ***
// Circular storage of result words, flip-flop based, indexed by pointers.
// Assumes the caller never pushes when full unless drop or pop is set.
`timescale 1ns/1ps
`default_nettype none
module safr_queue
	import safr_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// Clocking
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             clk_en,
	// Control
	input  wire logic             flush,
	input  wire logic             push,
	input  wire logic             drop,
	input  wire logic [WIDTH-1:0] push_data,
	input  wire logic             pop,
	input  wire logic [4:0]       limit,
	// State
	output logic      [WIDTH-1:0] head_data,
	output logic      [4:0]       count
);
	initial begin
		if (DEPTH < 2 || DEPTH > 16)
			$error("safr_queue depth out of range");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [3:0]       rd_ptr;
	logic [3:0]       wr_ptr;
	logic             full;
	logic             do_pop;
	logic             do_push;
	assign full      = (count >= limit);
	// Overflow drops the oldest by forcing a pop alongside the push
	assign do_pop    = (pop && count != 5'h00) || (push && drop && full);
	assign do_push   = push && (!full || drop || pop);
	assign head_data = mem[rd_ptr];
	always_ff @(posedge ref_clk) begin
		if (rst || (clk_en && flush)) begin
			rd_ptr <= 4'h0;
			wr_ptr <= 4'h0;
			count  <= 5'h00;
		end else if (clk_en) begin
			if (do_push) begin
				mem[wr_ptr] <= push_data;
				wr_ptr      <= (wr_ptr == 4'(DEPTH - 1)) ? 4'h0 : wr_ptr + 4'h1;
			end
			if (do_pop)
				rd_ptr <= (rd_ptr == 4'(DEPTH - 1)) ? 4'h0 : rd_ptr + 4'h1;
			count <= count + 5'(do_push) - 5'(do_pop);
		end
	end
endmodule
`default_nettype wire

// *** verif/safr_host_model.sv ***
// Host side of the command port: issues one command, returns the answer.
// Assumes the answer arrives on the taking edge, one clock after the command is driven.
`timescale 1ns/1ps
`default_nettype none
module safr_host_model
	import safr_pkg::*;
(
	// Clock
	input  wire logic                 ref_clk,
	// Answer from the device
	input  wire logic                 rd_valid,
	input  wire logic [WORD_BITS-1:0] rd_data,
	// Command to the device
	output logic                      cmd_valid,
	output logic      [7:0]           cmd_byte
);
	initial begin
		cmd_valid = 1'b0;
		cmd_byte = 8'h00;
	end

	// Idle byte is the inverse, so a stale byte never passes for a command
	task automatic access(input logic [7:0] b, output logic [WORD_BITS-1:0] w);
		@(posedge ref_clk);
		cmd_valid <= 1'b1;
		cmd_byte <= b;
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
		cmd_byte <= ~b;
		#1;
		w = rd_data;
	endtask
endmodule
`default_nettype wire

// *** verif/safr_flags_tb.sv ***
// Self-checking bench for the status, limit and result queue block.
// Assumes the host model on the command port and a 50 ns clock.
`timescale 1ns/1ps
`default_nettype none
module safr_flags_tb
	import safr_pkg::*;
;
	logic        ref_clk, rst, s_v, t_mode, t_v, t_cfg, t_rdy, rd_valid, cmd_valid;
	logic        wd, fr, lc, qc, ovr, ce;
	logic [3:0]  busy, s_tag, t_tag;
	logic [11:0] lim, s_res, lexp;
	logic [12:0] t_dat;
	logic [7:0]  cmd_byte;
	logic [15:0] rd_data, stat, limf, d, e;
	logic [31:0] seed;
	logic [15:0] q[$];
	int          mismatches, cmp_count;

	safr_flags uut (.ref_clk(ref_clk), .rst(rst), .clk_en(ce), .cmd_valid(cmd_valid),
		.cmd_byte(cmd_byte), .rd_valid(rd_valid), .rd_data(rd_data), .watchdog_reset(wd),
		.full_reset_cmd(fr), .limit_clear_cmd(lc), .queue_clear_bit(qc),
		.arith_unit_active(busy[3]), .gain_cal_active(busy[2]), .conversion_active(busy[1]),
		.gate_calc_active(busy[0]), .ch2_gate_over_limit(lim[11]),
		.ch2_gate_under_limit(lim[10]), .ch2_sense_over_limit(lim[9]),
		.ch2_sense_under_limit(lim[8]), .ch2_temp_over_limit(lim[7]),
		.ch2_temp_under_limit(lim[6]), .ch1_gate_over_limit(lim[5]),
		.ch1_gate_under_limit(lim[4]), .ch1_sense_over_limit(lim[3]),
		.ch1_sense_under_limit(lim[2]), .ch1_temp_over_limit(lim[1]),
		.ch1_temp_under_limit(lim[0]), .sample_valid(s_v), .sample_tag(s_tag),
		.sample_result(s_res), .table_mode(t_mode), .table_valid(t_v), .table_config(t_cfg),
		.table_data(t_dat), .table_tag(t_tag), .table_ready(t_rdy),
		.busy_status_flags(stat), .limit_violation_flags(limf));

	safr_host_model host (.ref_clk(ref_clk), .rd_valid(rd_valid), .rd_data(rd_data),
		.cmd_valid(cmd_valid), .cmd_byte(cmd_byte));

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	function automatic logic [31:0] nxt();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic stop_test();
		$display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic push_s(input logic [3:0] tg, input logic [11:0] r);
		@(posedge ref_clk);
		s_v <= 1'b1;
		s_tag <= tg;
		s_res <= r;
		@(posedge ref_clk);
		s_v <= 1'b0;
		if (q.size() == CONV_DEPTH) begin
			void'(q.pop_front());
			ovr = 1'b1;
		end
		q.push_back({tg, r});
	endtask

	task automatic push_t(input logic cfg);
		logic [3:0]  tg;
		logic [12:0] dt;
		tg = 4'(nxt());
		dt = 13'(nxt());
		@(posedge ref_clk);
		t_v <= 1'b1;
		t_cfg <= cfg;
		t_tag <= tg;
		t_dat <= dt;
		@(posedge ref_clk);
		t_v <= 1'b0;
		if (q.size() < TABLE_DEPTH)
			q.push_back(cfg ? {tg[3:1], dt} : {tg, dt[11:0]});
	endtask

	task automatic drain();
		while (q.size() > 0) begin
			host.access(CMD_READ_QUEUE, d);
			chk({15'h0000, rd_valid}, 16'h0001);
			chk(d, q.pop_front());
		end
	endtask

	// Generous bound; the sequence needs well under a thousand clocks
	initial begin
		repeat (5000) @(posedge ref_clk);
		mismatches++;
		stop_test();
	end

	initial begin
		seed = 32'h291b1ced;
		rst = 1'b1;
		{s_v, t_mode, t_v, t_cfg, wd, fr, lc, qc, ovr, ce} = 10'h001;
		{busy, s_tag, t_tag, lim, s_res, t_dat, lexp} = '0;
		repeat (8) @(posedge ref_clk);
		#1;
		chk(stat, {9'h0, STAT_RESET});
		chk(limf, 16'h0000);
		@(posedge ref_clk);
		rst <= 1'b0;
		repeat (8) begin
			@(posedge ref_clk);
			busy <= 4'(nxt());
			tick(3);
			chk(stat, {9'h0, 1'b0, busy, 2'b10});
		end
		host.access(CMD_READ_STATUS, d);
		chk(d, {9'h0, 1'b0, busy, 2'b10});
		@(posedge ref_clk);
		ce <= 1'b0;
		busy <= ~busy;
		lim <= 12'hfff;
		tick(3);
		chk(stat, {9'h0, 1'b0, ~busy, 2'b10});
		chk(limf, 16'h0000);
		@(posedge ref_clk);
		ce <= 1'b1;
		lim <= 12'h000;
		for (int k = 0; k < 8; k++) begin
			@(posedge ref_clk);
			lim <= 12'(nxt());
			busy <= 4'h0;
			@(posedge ref_clk);
			lexp = lexp | lim;
			lim <= 12'h000;
			tick(3);
			chk(limf, {4'h0, lexp});
			if (k == 5) begin
				@(posedge ref_clk);
				lc <= 1'b1;
				@(posedge ref_clk);
				lc <= 1'b0;
				lexp = 12'h000;
				tick(3);
				chk(limf, 16'h0000);
			end else if (k[0]) begin
				host.access(CMD_READ_LIMIT, d);
				chk(d, {4'h0, lexp});
				lexp = 12'h000;
				tick(3);
				chk(limf, 16'h0000);
			end
		end
		for (int j = 0; j < 2; j++) begin
			@(posedge ref_clk);
			wd <= (j == 0);
			fr <= (j == 1);
			@(posedge ref_clk);
			wd <= 1'b0;
			fr <= 1'b0;
			tick(2);
			host.access(CMD_READ_STATUS, d);
			chk(d, 16'h0042);
			host.access(CMD_READ_STATUS, d);
			chk(d, 16'h0002);
		end
		@(posedge ref_clk);
		wd <= 1'b1;
		@(posedge ref_clk);
		wd <= 1'b0;
		rst <= 1'b1;
		tick(2);
		chk(stat, {9'h0, STAT_RESET});
		@(posedge ref_clk);
		rst <= 1'b0;
		repeat (20) push_s(4'(nxt() % 14), 12'(nxt()));
		e = q.pop_front();
		fork
			host.access(CMD_READ_QUEUE, d);
			begin
				@(posedge ref_clk);
				s_v <= 1'b1;
				s_res <= 12'h5a3;
				@(posedge ref_clk);
				s_v <= 1'b0;
			end
		join
		chk(d, e);
		q.push_back({TAG_CORRUPT, 12'h5a3});
		drain();
		host.access(CMD_READ_QUEUE, d);
		chk(d, {TAG_EMPTY, 5'h00, 7'h03});
		host.access(8'h12, d);
		chk({15'h0000, rd_valid}, 16'h0000);
		host.access(CMD_READ_STATUS, d);
		chk(d, {14'h0000, 1'b1, ovr});
		host.access(CMD_READ_STATUS, d);
		chk(d, 16'h0002);
		ovr = 1'b0;
		repeat (16) push_s(4'h3, 12'(nxt()));
		tick(2);
		chk(stat, {15'h0000, ovr});
		@(posedge ref_clk);
		qc <= 1'b1;
		@(posedge ref_clk);
		qc <= 1'b0;
		tick(3);
		chk(stat, 16'h0002);
		q.delete();
		@(posedge ref_clk);
		t_mode <= 1'b1;
		tick(2);
		for (int i = 0; i < 17; i++)
			push_t(i % 3 == 0);
		tick(3);
		chk({15'h0, t_rdy}, 16'h0000);
		chk(stat, 16'h0001);
		host.access(CMD_READ_QUEUE, d);
		chk(d, q.pop_front());
		tick(3);
		chk(stat, 16'h0000);
		push_t(1'b0);
		drain();
		host.access(CMD_READ_QUEUE, d);
		chk(d, {TAG_EMPTY, 5'h00, 7'h02});
		chk({15'h0000, t_rdy}, 16'h0001);
		stop_test();
	end
endmodule
`default_nettype wire
